// ===== core_irq_map.svh
`ifndef CORE_IRQ_MAP_SVH
`define CORE_IRQ_MAP_SVH

// register offsets on the plain register port
`define ADDR_IRQ_CONTROL 4'h0
`define ADDR_PERIPH_FLAG_1 4'h1
`define ADDR_PERIPH_FLAG_2 4'h2
`define ADDR_PERIPH_ENABLE_1 4'h3
`define ADDR_PERIPH_ENABLE_2 4'h4
`define ADDR_OPTION 4'h5
`define ADDR_CORE_STATUS 4'h6
`define ADDR_EVENT_STATUS 4'h7
`define ADDR_EVENT_MASK 4'h8

// irq_control_reg bit positions
`define BIT_GLOBAL_IRQ_ENABLE 7
`define BIT_PERIPHERAL_IRQ_ENABLE 6
`define BIT_TIMER0_WRAP_ENABLE 5
`define BIT_EXT_PIN_ENABLE 4
`define BIT_PIN_CHANGE_ENABLE 3
`define BIT_TIMER0_WRAP_FLAG 2
`define BIT_EXT_PIN_FLAG 1
`define BIT_PIN_CHANGE_FLAG 0

// option register: edge select position
`define BIT_EXT_EDGE_SELECT 6

// reset values
`define RST_IRQ_CONTROL 8'h00
`define RST_PERIPH 8'h00
`define RST_OPTION 8'hFF

// program counter vector on acceptance
`define IRQ_VECTOR 13'h0004

// event status bit positions
`define EV_ACCEPT 0
`define EV_WAKE 1
`define EV_RETURN 2

// latency from a pin event to the request, in instruction cycles
`define EXT_LATENCY_MIN 3
`define EXT_LATENCY_MAX 4

`endif

// ===== core_irq_pkg.sv
package core_irq_pkg;
   typedef enum logic [1:0] {ST_RUN, ST_SLEEP, ST_WAKE} core_state_t;
   typedef logic [7:0] reg8_t;
endpackage : core_irq_pkg

// ===== core_interrupt_logic.sv
// What this block does
// - flags set regardless of any enable bit
// - global enable bit 7 gates all sources
// - enabled flagged source vectors immediately when global set
// - every reset clears global enable
// - return-from-interrupt sets global enable again
// - two peripheral flag/enable registers, peripheral enable gate
// - accept: clear global, push return, load vector
// - pin event to vector: four or five cycles
// - pin edge per select bit sets flag bit 1
// - clearing bit 4 blocks pin interrupt
// - enabled pin edge wakes from sleep
// - timer wrap sets bit 2, masked by bit 5
// - upper pin group change sets bit 0, bit 3
// - only return address saved on entry
// - up to twelve request sources handled
// - wake with global set loads vector
// - enabled source wakes even with global clear
`timescale 1ns/100ps
`include "core_irq_map.svh"

module core_interrupt_logic
   import core_irq_pkg::*;
#(
   parameter int PC_WIDTH = 13,
   parameter int PERIPH_SOURCES = 9
)
(
   input wire logic clk_in, // instruction clock
   input wire logic srst_in, // synchronous reset, active high
   // register port
   input wire logic [3:0] reg_addr_in, // register address
   input wire logic [7:0] reg_wdata_in, // write data
   input wire logic reg_wr_in, // write strobe
   input wire logic reg_rd_in, // read strobe
   output logic [7:0] reg_rdata_out, // read data, cycle after strobe
   // pins from outside
   input wire logic ext_irq_pin_in, // external interrupt pin
   input wire logic [3:0] pin_group_b_hi_in, // pin group b bits 7..4
   // same-clock core and peripheral inputs
   input wire logic timer0_wrap_in, // pulse: timer0_count wrapped to zero
   input wire logic [15:0] periph_flag_set_in, // pulses: peripheral events
   input wire logic [PC_WIDTH-1:0] return_pc_in, // address to resume at
   input wire logic return_from_irq_op_in, // pulse: return op executed
   input wire logic sleep_op_in, // pulse: sleep op executed
   output logic irq_request_out, // level: gated request to core
   output logic vector_load_out, // pulse: load pc with vector
   output logic [PC_WIDTH-1:0] vector_pc_out, // vector address
   output logic stack_push_out, // pulse: push return address
   output logic [PC_WIDTH-1:0] stack_data_out, // return address pushed
   output logic wake_out, // pulse: leave sleep
   output logic sleeping_out, // level: core asleep
   output logic event_irq_out // level: unmasked event status set
);

   // refuse widths that the vector and the sixteen flag pulses cannot serve
   if (PC_WIDTH < 13 || PERIPH_SOURCES < 1 || PERIPH_SOURCES > 9)
   begin : g_bad_params
      $error("core_interrupt_logic: unsupported parameters");
   end

   // software-visible registers
   reg8_t ctrl_q; // irq_control_reg
   reg8_t pflag1_q; // periph_flag_reg_1
   reg8_t pflag2_q; // periph_flag_reg_2
   reg8_t pen1_q; // periph_enable_reg_1
   reg8_t pen2_q; // periph_enable_reg_2
   reg8_t option_q; // option, edge select in bit 6
   reg8_t ev_status_q; // sticky event status
   reg8_t ev_mask_q; // event mask
   core_state_t state_q; // run, sleep, wake
   // pin synchronisers and edge detection
   logic [1:0] ext_sync_q; // pin synchroniser
   logic ext_prev_q; // last synchronised pin level
   logic [3:0] rb_sync1_q; // group b first stage
   logic [3:0] rb_sync2_q; // group b second stage
   logic [3:0] rb_prev_q; // last synchronised group level
   logic ext_pipe_q; // one stage between edge and flag
   logic [1:0] settle_q; // cycles since reset, saturating
   logic settled; // synchronisers hold real pin levels
   logic ext_edge; // valid edge on the pin
   logic [3:0] rb_bit_change; // per-pin change
   logic rb_change; // any group b change
   // request gating
   logic core_hit; // core flag-and-enable pairs
   logic periph_pairs; // any peripheral flag-and-enable pair
   logic periph_hit; // pairs behind the peripheral gate
   logic any_hit; // any enabled source flagged
   logic accept; // request taken this cycle
   logic wake; // leave sleep this cycle
   logic [7:0] event_set; // event status set pulses
   // register write decodes
   logic wr_ctrl; // control register
   logic wr_pf1; // peripheral flags 1
   logic wr_pf2; // peripheral flags 2
   logic wr_pen1; // peripheral enables 1
   logic wr_pen2; // peripheral enables 2
   logic wr_opt; // option register
   logic wr_evs; // event status, write one to clear
   logic wr_evm; // event mask
   // constants
   logic [15:0] periph_mask; // live peripheral flags
   logic [PC_WIDTH-1:0] vector_pc; // vector address

   assign vector_pc = PC_WIDTH'(`IRQ_VECTOR);
   // only PERIPH_SOURCES + 3 core sources are live (twelve at most)
   assign periph_mask = 16'((17'h1 << PERIPH_SOURCES) - 17'h1);

   // two-stage synchronisers for pins from outside the clock domain
   // a pin may move anywhere in the cycle; only the second stage is read
   always_ff @(posedge clk_in)
   begin
      if (srst_in)
      begin
         ext_sync_q <= 2'h0;
         rb_sync1_q <= 4'h0;
         rb_sync2_q <= 4'h0;
      end
      else
      begin
         ext_sync_q <= {ext_sync_q[0], ext_irq_pin_in};
         rb_sync1_q <= pin_group_b_hi_in;
         rb_sync2_q <= rb_sync1_q;
      end
   end

   // previous sampled levels for edge and change detection
   // reset to low; the settle counter hides the first samples after reset
   always_ff @(posedge clk_in)
   begin
      if (srst_in)
      begin
         ext_prev_q <= 1'b0;
         rb_prev_q <= 4'h0;
      end
      else
      begin
         ext_prev_q <= ext_sync_q[1];
         rb_prev_q <= rb_sync2_q;
      end
   end

   // pins settle through the synchronisers before edges count; without this a
   // pin that idles high would show a false edge straight after reset
   always_ff @(posedge clk_in)
   begin
      if (srst_in)
         settle_q <= 2'h0;
      else if (settle_q != 2'h3)
         settle_q <= settle_q + 2'h1;
   end

   assign settled = (settle_q == 2'h3);

   // rising edge when select set, else falling
   assign ext_edge = settled & (option_q[`BIT_EXT_EDGE_SELECT]
                                ? (ext_sync_q[1] & ~ext_prev_q)
                                : (~ext_sync_q[1] & ext_prev_q));

   // one change detector per pin of the upper group; any of them sets the flag
   for (genvar i = 0; i < 4; i++)
   begin : g_rb_change
      assign rb_bit_change[i] = settled & (rb_sync2_q[i] ^ rb_prev_q[i]);
   end
   assign rb_change = |rb_bit_change;

   // synchronisers plus this stage: the flag lands three to four cycles after
   // the pin moves, depending on where in the cycle it moved
   always_ff @(posedge clk_in)
   begin
      if (srst_in)
         ext_pipe_q <= 1'b0;
      else
         ext_pipe_q <= ext_edge;
   end

   // one decode per register keeps the processes below free of address compares
   assign wr_ctrl = reg_wr_in && (reg_addr_in == `ADDR_IRQ_CONTROL);
   assign wr_pf1 = reg_wr_in && (reg_addr_in == `ADDR_PERIPH_FLAG_1);
   assign wr_pf2 = reg_wr_in && (reg_addr_in == `ADDR_PERIPH_FLAG_2);
   assign wr_pen1 = reg_wr_in && (reg_addr_in == `ADDR_PERIPH_ENABLE_1);
   assign wr_pen2 = reg_wr_in && (reg_addr_in == `ADDR_PERIPH_ENABLE_2);
   assign wr_opt = reg_wr_in && (reg_addr_in == `ADDR_OPTION);
   assign wr_evs = reg_wr_in && (reg_addr_in == `ADDR_EVENT_STATUS);
   assign wr_evm = reg_wr_in && (reg_addr_in == `ADDR_EVENT_MASK);

   // request gating: global AND (core pairs OR peripheral gate AND periph pairs)
   assign core_hit = (ctrl_q[`BIT_EXT_PIN_FLAG] & ctrl_q[`BIT_EXT_PIN_ENABLE])
                   | (ctrl_q[`BIT_TIMER0_WRAP_FLAG] & ctrl_q[`BIT_TIMER0_WRAP_ENABLE])
                   | (ctrl_q[`BIT_PIN_CHANGE_FLAG] & ctrl_q[`BIT_PIN_CHANGE_ENABLE]);
   // dead peripheral sources are masked so they can never raise a request
   assign periph_pairs = |({pflag2_q, pflag1_q} & {pen2_q, pen1_q} & periph_mask);
   assign periph_hit = ctrl_q[`BIT_PERIPHERAL_IRQ_ENABLE] & periph_pairs;
   // any_hit ignores the global enable: sleep refuses to start when one is pending
   assign any_hit = core_hit | periph_hit;
   assign irq_request_out = ctrl_q[`BIT_GLOBAL_IRQ_ENABLE] & any_hit;
   // wake ignores the global enable; sleep waits for the enabled source
   assign wake = (state_q == ST_SLEEP) && any_hit;
   // no acceptance while asleep: the core first runs the prefetched op
   // acceptance in the wake cycle ends that op, then the vector follows
   assign accept = irq_request_out && (state_q != ST_SLEEP);

   // irq_control_reg: flags set by hardware win over software writes
   // software write first, then hardware events override the written bits;
   // acceptance beats a same-cycle return op so the global bit cannot stick set
   always_ff @(posedge clk_in)
   begin
      if (srst_in)
         ctrl_q <= `RST_IRQ_CONTROL;
      else
      begin
         if (wr_ctrl)
            ctrl_q <= reg_wdata_in;
         if (accept)
            ctrl_q[`BIT_GLOBAL_IRQ_ENABLE] <= 1'b0;
         else if (return_from_irq_op_in)
            ctrl_q[`BIT_GLOBAL_IRQ_ENABLE] <= 1'b1;
         // events set regardless of any enable
         if (ext_pipe_q)
            ctrl_q[`BIT_EXT_PIN_FLAG] <= 1'b1;
         if (timer0_wrap_in)
            ctrl_q[`BIT_TIMER0_WRAP_FLAG] <= 1'b1;
         if (rb_change)
            ctrl_q[`BIT_PIN_CHANGE_FLAG] <= 1'b1;
      end
   end

   // peripheral flag registers, set wins over write
   // hardware never sets dead sources; only a software write can set a flag with no source
   always_ff @(posedge clk_in)
   begin
      if (srst_in)
      begin
         pflag1_q <= `RST_PERIPH;
         pflag2_q <= `RST_PERIPH;
      end
      else
      begin
         pflag1_q <= (wr_pf1 ? reg_wdata_in : pflag1_q)
                   | (periph_flag_set_in[7:0] & periph_mask[7:0]);
         pflag2_q <= (wr_pf2 ? reg_wdata_in : pflag2_q)
                   | (periph_flag_set_in[15:8] & periph_mask[15:8]);
      end
   end

   // peripheral enables and option register
   always_ff @(posedge clk_in)
   begin
      if (srst_in)
      begin
         pen1_q <= `RST_PERIPH;
         pen2_q <= `RST_PERIPH;
         option_q <= `RST_OPTION;
      end
      else
      begin
         if (wr_pen1)
            pen1_q <= reg_wdata_in;
         if (wr_pen2)
            pen2_q <= reg_wdata_in;
         if (wr_opt)
            option_q <= reg_wdata_in;
      end
   end

   // sleep state; wake state holds one cycle for the prefetched op
   // the wake state lets the core run that op before any vector is taken
   always_ff @(posedge clk_in)
   begin
      if (srst_in)
         state_q <= ST_RUN;
      else
      begin
         unique case (state_q)
            ST_RUN:
               if (sleep_op_in && !any_hit)
                  state_q <= ST_SLEEP; // pending enabled source makes sleep a no-op
            ST_SLEEP:
               if (wake)
                  state_q <= ST_WAKE;
            ST_WAKE:
               state_q <= ST_RUN;
         endcase
      end
   end

   // vector outputs; the vector is constant but leaves through a flop
   // like every other data output
   always_ff @(posedge clk_in)
   begin
      if (srst_in)
      begin
         vector_load_out <= 1'b0;
         vector_pc_out <= '0;
      end
      else
      begin
         vector_load_out <= accept;
         vector_pc_out <= vector_pc;
      end
   end

   // stack outputs: only the return pc is saved, the rest is software's
   always_ff @(posedge clk_in)
   begin
      if (srst_in)
      begin
         stack_push_out <= 1'b0;
         stack_data_out <= '0;
      end
      else
      begin
         stack_push_out <= accept;
         if (accept)
            stack_data_out <= return_pc_in;
      end
   end

   // wake pulse, one cycle as the sleep state is left
   always_ff @(posedge clk_in)
   begin
      if (srst_in)
         wake_out <= 1'b0;
      else
         wake_out <= wake;
   end

   assign sleeping_out = (state_q == ST_SLEEP);

   // event pulses in their status positions
   assign event_set = {5'h00, return_from_irq_op_in, wake, accept};

   // sticky event status, write one to clear, set wins
   // an event in the same cycle as a clearing write keeps its bit set
   always_ff @(posedge clk_in)
   begin
      if (srst_in)
      begin
         ev_status_q <= 8'h00;
         ev_mask_q <= 8'h00;
      end
      else
      begin
         if (wr_evm)
            ev_mask_q <= reg_wdata_in;
         ev_status_q <= (wr_evs ? (ev_status_q & ~reg_wdata_in) : ev_status_q) | event_set;
      end
   end

   // separate from the core request: this line is for a supervisor, not the core
   assign event_irq_out = |(ev_status_q & ev_mask_q);

   // read data one cycle after the strobe, zero elsewhere
   // unmapped addresses read as zero; the data stand for one cycle only
   always_ff @(posedge clk_in)
   begin
      if (srst_in)
         reg_rdata_out <= 8'h00;
      else if (reg_rd_in)
      begin
         unique case (reg_addr_in)
            `ADDR_IRQ_CONTROL: reg_rdata_out <= ctrl_q;
            `ADDR_PERIPH_FLAG_1: reg_rdata_out <= pflag1_q;
            `ADDR_PERIPH_FLAG_2: reg_rdata_out <= pflag2_q;
            `ADDR_PERIPH_ENABLE_1: reg_rdata_out <= pen1_q;
            `ADDR_PERIPH_ENABLE_2: reg_rdata_out <= pen2_q;
            `ADDR_OPTION: reg_rdata_out <= option_q;
            `ADDR_CORE_STATUS: reg_rdata_out <= {6'h00, sleeping_out, irq_request_out};
            `ADDR_EVENT_STATUS: reg_rdata_out <= ev_status_q;
            `ADDR_EVENT_MASK: reg_rdata_out <= ev_mask_q;
            default: reg_rdata_out <= 8'h00;
         endcase
      end
      else
         reg_rdata_out <= 8'h00;
   end

endmodule : core_interrupt_logic

// ===== core_irq_properties.sv
`timescale 1ns/100ps
// port-level watch on the interrupt block
module core_irq_properties
#(
   parameter int PC_WIDTH = 13
)
(
   input wire logic clk_in, // clock
   input wire logic srst_in, // reset
   input wire logic [3:0] reg_addr_in, // address
   input wire logic reg_rd_in, // read strobe
   input wire logic [7:0] reg_rdata_out, // read data
   input wire logic [PC_WIDTH-1:0] return_pc_in, // resume pc
   input wire logic irq_request_out, // request
   input wire logic vector_load_out, // vector pulse
   input wire logic [PC_WIDTH-1:0] vector_pc_out, // vector
   input wire logic stack_push_out, // push pulse
   input wire logic [PC_WIDTH-1:0] stack_data_out, // pushed pc
   input wire logic wake_out, // wake pulse
   input wire logic sleeping_out // asleep
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (srst_in);
   // sleep defers acceptance; sleep and its wake cycle are both excluded, though the wake cycle accepts
   take_vector_a: assert property (irq_request_out && !sleeping_out && !wake_out
      |=> vector_load_out && stack_push_out) else $error("request not taken");
   vector_entry_a: assert property (vector_load_out
      |-> vector_pc_out == PC_WIDTH'(4) && !irq_request_out) else $error("bad entry");
   push_pc_a: assert property (irq_request_out && !sleeping_out && !wake_out
      |=> stack_data_out == $past(return_pc_in)) else $error("wrong pc pushed");
   reset_quiet_a: assert property ($fell(srst_in)
      |-> !irq_request_out) else $error("request after reset");
   read_idle_a: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 8'h00)
      else $error("read data not idle");
   unmapped_zero_a: assert property ($past(reg_rd_in && reg_addr_in > 4'h8)
      |-> reg_rdata_out == 8'h00) else $error("unmapped read");
   status_read_a: assert property ($past(reg_rd_in && reg_addr_in == 4'h6)
      |-> reg_rdata_out[1:0] == $past({sleeping_out, irq_request_out})) else $error("status");
   wake_once_a: assert property (wake_out |-> $past(sleeping_out) ##1 !wake_out)
      else $error("wake pulse wrong");
endmodule : core_irq_properties

bind core_interrupt_logic core_irq_properties #(.PC_WIDTH(PC_WIDTH)) core_irq_properties_i (.*);

// ===== core_seq_model.sv
`timescale 1ns/100ps
// core stand-in: running pc, return op a cycle after go
module core_seq_model
(
   input wire logic clk_in, // clock
   input wire logic srst_in, // reset
   input wire logic ret_go_in, // service done
   output logic [12:0] pc_out, // resume pc
   output logic ret_op_out // return pulse
);
   // pc keeps moving so every push shows a fresh value
   always_ff @(posedge clk_in)
   begin
      pc_out <= srst_in ? 13'h0000 : pc_out + 13'h0001;
   end
   // return only when the service routine says so
   always_ff @(posedge clk_in)
   begin
      ret_op_out <= ret_go_in && !srst_in;
   end
endmodule : core_seq_model

// ===== testbench.sv
`timescale 1ns/100ps
`include "core_irq_map.svh"
module testbench;
   logic clk_in = 1'b0, srst_in = 1'b1, reg_wr_in = 1'b0, reg_rd_in = 1'b0, go = 1'b0;
   logic ext_irq_pin_in = 1'b0, timer0_wrap_in = 1'b0, sleep_op_in = 1'b0;
   logic [3:0] reg_addr_in = 4'h0, pin_group_b_hi_in = 4'h0;
   logic [7:0] reg_wdata_in = 8'h00, reg_rdata_out;
   logic [15:0] periph_flag_set_in = 16'h0000;
   logic [12:0] return_pc_in, vector_pc_out, stack_data_out;
   logic return_from_irq_op_in, irq_request_out, vector_load_out, stack_push_out;
   logic wake_out, sleeping_out, event_irq_out;
   int bad_count = 0, checks_done = 0, cycles = 0, vecs = 0, n, k;

   always #2.5 clk_in = ~clk_in;
   core_interrupt_logic core_interrupt_logic_i (.*);
   core_seq_model core_seq_model_i (.clk_in(clk_in), .srst_in(srst_in), .ret_go_in(go),
      .pc_out(return_pc_in), .ret_op_out(return_from_irq_op_in));

   task automatic chk(input logic [12:0] seen, input logic [12:0] want);
      checks_done++;
      if (seen !== want)
      begin
         bad_count++;
         $display("BAD %0t: got %h not %h", $time, seen, want);
      end
   endtask : chk
   task automatic cyc(input int c);
      repeat (c) @(posedge clk_in);
   endtask : cyc
   // strobe then an idle cycle, so no strobe is driven twice at one edge
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      reg_addr_in <= a;
      reg_wdata_in <= d;
      reg_wr_in <= 1'b1;
      cyc(1);
      reg_wr_in <= 1'b0;
      cyc(1);
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [7:0] want);
      reg_addr_in <= a;
      reg_rd_in <= 1'b1;
      cyc(1);
      reg_rd_in <= 1'b0;
      cyc(1);
      chk(reg_rdata_out, want);
   endtask : rd
   // pulse: 0 timer wrap, 1 sleep op, 2 service done
   task automatic fire(input int s);
      timer0_wrap_in <= (s == 0);
      sleep_op_in <= (s == 1);
      go <= (s == 2);
      cyc(1);
      {timer0_wrap_in, sleep_op_in, go} <= 3'b000;
      cyc(1);
   endtask : fire
   task automatic await_vec;
      k = 0;
      while (vector_load_out !== 1'b1 && k < 20)
      begin
         cyc(1);
         k++;
      end
   endtask : await_vec
   task automatic conclude;
      $display("checks %0d, mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : conclude

   // run watchdog and tally of vector pulses
   always @(posedge clk_in)
   begin
      cycles++;
      vecs += (vector_load_out === 1'b1);
      if (cycles == 3000)
      begin
         bad_count++;
         conclude();
      end
   end

   initial
   begin
      cyc(3);
      srst_in <= 1'b0;
      rd(4'h0, 8'h00);
      rd(4'h5, 8'hFF);
      rd(4'hF, 8'h00);
      // both edges under both select settings, no enables set
      for (n = 0; n < 4; n++)
      begin
         if (n == 2)
            wr(4'h5, 8'hBF);
         ext_irq_pin_in <= ~ext_irq_pin_in;
         cyc(8);
         rd(4'h0, {6'h00, n == 0 || n == 3, 1'b0});
         wr(4'h0, 8'h00);
      end
      fire(0);
      rd(4'h0, 8'h04);
      pin_group_b_hi_in <= 4'h4;
      cyc(8);
      rd(4'h0, 8'h05);
      wr(4'h0, 8'h00);
      periph_flag_set_in <= 16'h0101;
      cyc(1);
      periph_flag_set_in <= 16'h0000;
      rd(4'h2, 8'h01);
      wr(4'h3, 8'h01);
      wr(4'h8, 8'h01);
      wr(4'h0, 8'h80);
      rd(4'h6, 8'h00);
      wr(4'h0, 8'hC0);
      await_vec();
      chk(k < 20, 1'b1);
      rd(4'h0, 8'h40);
      chk(event_irq_out, 1'b1);
      // flag left set: the return brings the same request back
      fire(2);
      await_vec();
      chk(k < 20, 1'b1);
      wr(4'h1, 8'h00);
      fire(2);
      cyc(3);
      rd(4'h0, 8'hC0);
      wr(4'h7, 8'h07);
      chk(event_irq_out, 1'b0);
      wr(4'h5, 8'hFF);
      wr(4'h0, 8'h90);
      ext_irq_pin_in <= 1'b1;
      await_vec();
      chk(13'(k), 13'(`EXT_LATENCY_MAX + 2));
      rd(4'h0, 8'h12);
      // sleep with global clear: timer wakes, no vector
      wr(4'h0, 8'h20);
      fire(1);
      chk(sleeping_out, 1'b1);
      fire(0);
      cyc(4);
      chk(sleeping_out, 1'b0);
      chk(vecs[12:0], 13'h0003);
      ext_irq_pin_in <= 1'b0;
      wr(4'h0, 8'h80);
      ext_irq_pin_in <= 1'b1;
      cyc(8);
      chk(vecs[12:0], 13'h0003);
      // asleep with pin and global enabled: wake, then vector
      wr(4'h0, 8'h90);
      ext_irq_pin_in <= 1'b0;
      fire(1);
      ext_irq_pin_in <= 1'b1;
      await_vec();
      chk(k < 20, 1'b1);
      conclude();
   end
endmodule : testbench
